// File: hdl/bcs_pkg.sv
// Constants shared by the boot clock and source control block.
package bcs_pkg;
	// ****************************************
	// Register map (byte offsets)
	// ****************************************
	localparam logic [7:0] OFF_CTRL   = 8'h00; // Boot mode, bypass, PLL resets.
	localparam logic [7:0] OFF_SRCSEL = 8'h04; // Source select per block.
	localparam logic [7:0] OFF_PCNT   = 8'h08; // Processor clock count field.
	localparam logic [7:0] OFF_PDIV   = 8'h0C; // Peripheral bus divider.
	localparam logic [7:0] OFF_EN     = 8'h10; // Gates and peripheral enables.
	localparam logic [7:0] OFF_STAT   = 8'h14; // Live status.
	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int CTRL_BOOT = 0; // Boot mode bit.
	localparam int CTRL_BYP  = 1; // Force PLL bypass bit.
	localparam int CTRL_PRST = 2; // PLL reset bits 3:2.
	localparam int SEL_W     = 8; // Bits per block in SRCSEL.
	localparam int EN_PER    = 4; // Peripheral enables start one bit below this.
	localparam logic [7:0] PCNT_RST = 8'h00; // Full speed.
	localparam logic [7:0] PDIV_RST = 8'h01; // Divide by two.
	localparam logic [6:0] EN_RST   = 7'h7F; // All enabled.
	localparam logic [7:0] SAFE_DIV = 8'h00; // Boot-safe divider.
	// ****************************************
	// Source codes and pin vector layout
	// ****************************************
	localparam logic [2:0] SRC_OSC  = 3'h0; // External oscillator.
	localparam logic [2:0] SRC_FAB  = 3'h1; // Fabric reference.
	localparam logic [2:0] SRC_INT  = 3'h2; // Halved internal oscillator.
	localparam logic [2:0] SRC_MPLL = 3'h3; // Main PLL counter.
	localparam logic [2:0] SRC_PPLL = 3'h4; // Peripheral PLL counter.
	localparam logic [3:0] CNT_MAX  = 4'h8; // Highest PLL counter.
	localparam int PIN_MAIN  = 0;  // Main PLL counters 8:0.
	localparam int PIN_PER   = 9;  // Peripheral PLL counters 17:9.
	localparam int PIN_EXT   = 18; // External oscillator.
	localparam int PIN_FAB   = 19; // Fabric reference.
	localparam int PIN_INT   = 20; // Internal fast oscillator.
	localparam int PIN_WARM  = 21; // Warm boot request.
	localparam int PIN_STRAP = 22; // Boot source strap.
	localparam int PIN_W     = 23; // Pin vector width.
	// ****************************************
	// Frequency limits
	// ****************************************
	localparam int CLK_MHZ     = 20;  // Register clock rate.
	localparam int PB_MAX_MHZ  = 200; // Peripheral bus ceiling.
	localparam int SRC_MAX_MHZ = 400; // Fastest selectable source.
	localparam logic [7:0] PB_MIN_DIV =
		8'((SRC_MAX_MHZ + PB_MAX_MHZ - 1) / PB_MAX_MHZ - 1);
endpackage : bcs_pkg

// File: hdl/bcs_clk_ctrl.sv
// Boot clock generation, source selection, dividers and gates.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - Peripheral bus clock kept at or below 200 MHz
// - Boot clock is default, sequencer, bypass reference
// - Boot clock from halved internal or external
// - Boot source latched only at boot exits
// - Bypass source of each block is boot clock
// - Five sources, PLL counters zero to eight
// - Each block has a bypass multiplexer
// - Hardware or software gates, optional dividers
// - Processor and interconnect ratio enables
// - Registers run on free system clock
// - PLL update forces boot-safe dividers, no reset
// - Boot mode and bypass changeable while running
// - Processor count field slows processor clock
// - Peripheral enables reset to enabled
// - Boot mode forces peripheral enables on
module bcs_clk_ctrl (
	input  wire logic        clk_in,            // Free system clock.
	input  wire logic        srst_in,           // Sync reset, high.
	input  wire logic [7:0]  addr_in,           // Register byte address.
	input  wire logic [31:0] wdata_in,          // Write data.
	input  wire logic        wr_in,             // Write strobe.
	input  wire logic        rd_in,             // Read strobe.
	output logic      [31:0] rdata_out,         // Read data, next cycle.
	input  wire logic        boot_src_strap_in, // 1 selects ext osc.
	input  wire logic        warm_boot_req_in,  // Warm boot request pin.
	input  wire logic        external_oscillator_input, // Osc pin.
	input  wire logic        fabric_free_reference,     // Fabric ref.
	input  wire logic        int_fast_osc_in,   // Internal fast osc.
	input  wire logic [8:0]  main_pll_in,       // Main PLL counters.
	input  wire logic [8:0]  peripheral_pll_in, // Periph PLL counters.
	output logic             boot_clk_out,      // Boot reference clock.
	output logic             proc_clk_out,      // Processor clock.
	output logic             noc_clk_out,       // Interconnect clock.
	output logic             peripheral_bus_clock, // Periph bus clock.
	output logic             proc_half_en_out,  // Processor 1:2 enable.
	output logic             proc_qtr_en_out,   // Processor 1:4 enable.
	output logic             noc_half_en_out,   // Interconnect 1:2.
	output logic             noc_qtr_en_out,    // Interconnect 1:4.
	output logic [3:0]       periph_en_out,     // Peripheral enables.
	output logic [1:0]       pll_rst_out,       // PLL resets.
	output logic             pll_byp_out        // PLL bypass.
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [bcs_pkg::PIN_W-1:0] pin_raw;  // Raw pins.
	logic [bcs_pkg::PIN_W-1:0] pin_s1_r; // First stage.
	logic [bcs_pkg::PIN_W-1:0] pin_r;    // Second stage, safe to use.
	logic [bcs_pkg::PIN_W-1:0] pin_q_r;  // Previous safe value.
	assign pin_raw = {boot_src_strap_in, warm_boot_req_in,
		int_fast_osc_in, fabric_free_reference,
		external_oscillator_input, peripheral_pll_in, main_pll_in};
	// Two flops per pin, then a third copy for edge detection.
	always_ff @(posedge clk_in) begin
		pin_s1_r <= pin_raw;
		pin_r    <= pin_s1_r;
		pin_q_r  <= pin_r;
	end
	// ****************************************
	// Register file
	// ****************************************
	logic [2:0]  ctrl_r;   // PLL resets and bypass.
	logic [23:0] srcsel_r; // Eight bits per output block.
	logic [7:0]  pcnt_r;   // Processor clock count field.
	logic [7:0]  pdiv_r;   // Peripheral bus divider.
	logic [6:0]  en_r;     // Gates 2:0, peripheral enables 6:3.
	logic [31:0] rdata_r;  // Read data.
	logic        boot_mode_r; // Boot mode state.
	logic        boot_sel_r;  // Latched boot source.
	logic [2:0]  byp_vec;     // Applied bypass per block, for status.
	// Software settings; the registers stay reachable on this clock.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_r   <= 3'h0;
			srcsel_r <= 24'h000000;
			pcnt_r   <= bcs_pkg::PCNT_RST;
			pdiv_r   <= bcs_pkg::PDIV_RST;
			en_r     <= bcs_pkg::EN_RST;
		end else if (wr_in) begin
			case (addr_in)
				bcs_pkg::OFF_CTRL: begin
					ctrl_r <= wdata_in[bcs_pkg::CTRL_BYP +: 3];
				end
				bcs_pkg::OFF_SRCSEL: begin
					srcsel_r <= wdata_in[23:0];
				end
				bcs_pkg::OFF_PCNT: begin
					pcnt_r <= wdata_in[7:0];
				end
				bcs_pkg::OFF_PDIV: begin
					pdiv_r <= wdata_in[7:0];
				end
				bcs_pkg::OFF_EN: begin
					en_r <= wdata_in[6:0];
				end
				default: begin
					en_r <= en_r; // Other offsets store nothing.
				end
			endcase
		end
	end
	// Read mux; data stand in the cycle after the strobe only.
	always_ff @(posedge clk_in) begin
		if (srst_in || !rd_in) begin
			rdata_r <= 32'h00000000;
		end else begin
			case (addr_in)
				bcs_pkg::OFF_CTRL:   rdata_r <= {28'h0000000, ctrl_r,
					boot_mode_r};
				bcs_pkg::OFF_SRCSEL: rdata_r <= {8'h00, srcsel_r};
				bcs_pkg::OFF_PCNT:   rdata_r <= {24'h000000, pcnt_r};
				bcs_pkg::OFF_PDIV:   rdata_r <= {24'h000000, pdiv_r};
				bcs_pkg::OFF_EN:     rdata_r <= {25'h0000000, en_r};
				bcs_pkg::OFF_STAT:   rdata_r <= {27'h0000000, byp_vec,
					boot_sel_r, boot_mode_r};
				default:             rdata_r <= 32'h00000000;
			endcase
		end
	end
	assign rdata_out = rdata_r;
	// ****************************************
	// Boot source latch and boot mode
	// ****************************************
	logic in_rst_r;  // Reset was high last cycle.
	logic warm_rise; // Warm boot request edge.
	logic cap_boot;  // Moment to sample the strap.
	logic int_half_r; // Internal oscillator divided by two.
	logic boot_lvl;  // Boot clock level.
	assign warm_rise = pin_r[bcs_pkg::PIN_WARM] &
		!pin_q_r[bcs_pkg::PIN_WARM];
	assign cap_boot = (in_rst_r & !srst_in) | warm_rise;
	// Tracks reset so that its release can be seen.
	always_ff @(posedge clk_in) begin
		in_rst_r <= srst_in;
	end
	// Strap is sampled only on leaving reset or on a warm request.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			boot_sel_r <= 1'b0;
		end else if (cap_boot) begin
			boot_sel_r <= pin_r[bcs_pkg::PIN_STRAP];
		end
	end
	// Halves the internal oscillator on each of its rising edges.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			int_half_r <= 1'b0;
		end else if (pin_r[bcs_pkg::PIN_INT] &&
			!pin_q_r[bcs_pkg::PIN_INT]) begin
			int_half_r <= !int_half_r;
		end
	end
	// Boot clock is the external oscillator or the halved internal one.
	assign boot_lvl = boot_sel_r ? pin_r[bcs_pkg::PIN_EXT] : int_half_r;
	// Boot clock output.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			boot_clk_out <= 1'b0;
		end else begin
			boot_clk_out <= boot_lvl;
		end
	end
	// Boot mode after reset; a warm request beats a software clear.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			boot_mode_r <= 1'b1;
		end else if (warm_rise) begin
			boot_mode_r <= 1'b1;
		end else if (wr_in && addr_in == bcs_pkg::OFF_CTRL) begin
			boot_mode_r <= wdata_in[bcs_pkg::CTRL_BOOT];
		end
	end
	// ****************************************
	// PLL control and peripheral enables
	// ****************************************
	logic safe_mode; // Blocks must run from boot-safe settings.
	assign safe_mode = boot_mode_r | ctrl_r[0] | (|ctrl_r[2:1]);
	// PLL reset and bypass outputs follow software, no block reset.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pll_rst_out <= 2'h0;
			pll_byp_out <= 1'b1;
		end else begin
			pll_rst_out <= ctrl_r[2:1];
			pll_byp_out <= safe_mode;
		end
	end
	// Peripheral enables, forced on during boot mode.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			periph_en_out <= 4'hF;
		end else if (boot_mode_r) begin
			periph_en_out <= 4'hF;
		end else begin
			periph_en_out <= en_r[bcs_pkg::EN_PER-1 +: 4];
		end
	end
	// ****************************************
	// Output clock blocks
	// ****************************************
	// Level of one of the five non-bypass sources.
	function automatic logic src_level(input logic [2:0] s,
		input logic [3:0] i, input logic [bcs_pkg::PIN_W-1:0] v,
		input logic ih);
		logic l;
		l = 1'b0;
		case (s)
			bcs_pkg::SRC_OSC:  l = v[bcs_pkg::PIN_EXT];
			bcs_pkg::SRC_FAB:  l = v[bcs_pkg::PIN_FAB];
			bcs_pkg::SRC_INT:  l = ih;
			bcs_pkg::SRC_MPLL: l = (i <= bcs_pkg::CNT_MAX) &&
				v[bcs_pkg::PIN_MAIN + int'(i)];
			bcs_pkg::SRC_PPLL: l = (i <= bcs_pkg::CNT_MAX) &&
				v[bcs_pkg::PIN_PER + int'(i)];
			default:           l = 1'b0;
		endcase
		return l;
	endfunction : src_level
	genvar b;
	generate
		for (b = 0; b < 3; b++) begin : g_blk
			logic [2:0] src_r;  // Applied source.
			logic [3:0] idx_r;  // Applied PLL counter.
			logic [7:0] div_r;  // Applied divider minus one.
			logic [7:0] cnt_r;  // Divider count.
			logic [7:0] want_div; // Requested divider.
			logic       byp_r;  // Applied bypass.
			logic       gate_r; // Applied gate.
			logic       s_lvl;  // Muxed source level.
			logic       s_q_r;  // Previous source level.
			logic       hit_r;  // This source period is passed on.
			logic       out_r;  // Output clock.
			logic       out_q_r; // Previous output.
			logic [1:0] rc_r;   // Output edge count.
			logic       half_r; // Ratio 1:2 enable.
			logic       qtr_r;  // Ratio 1:4 enable.
			// Bypass mux picks the boot clock over the chosen source.
			assign s_lvl = byp_r ? boot_lvl : src_level(src_r, idx_r,
				pin_r, int_half_r);
			// Divider request per block; safe mode uses boot-safe values.
			always_comb begin
				if (safe_mode) begin
					want_div = bcs_pkg::SAFE_DIV;
				end else if (b == 0) begin
					want_div = pcnt_r;
				end else if (b == 1) begin
					want_div = bcs_pkg::SAFE_DIV;
				end else begin
					want_div = pdiv_r;
				end
				if (b == 2 && want_div < bcs_pkg::PB_MIN_DIV) begin
					want_div = bcs_pkg::PB_MIN_DIV;
				end
			end
			// New settings land only while source and output are low.
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					byp_r  <= 1'b1;
					src_r  <= bcs_pkg::SRC_OSC;
					idx_r  <= 4'h0;
					div_r  <= (b == 2) ? bcs_pkg::PB_MIN_DIV :
						bcs_pkg::SAFE_DIV;
					gate_r <= 1'b1;
				end else if (!s_lvl && !out_r) begin
					byp_r  <= safe_mode;
					src_r  <= srcsel_r[b*bcs_pkg::SEL_W +: 3];
					idx_r  <= srcsel_r[b*bcs_pkg::SEL_W+3 +: 4];
					div_r  <= want_div;
					gate_r <= en_r[b] | boot_mode_r;
				end
			end

			// Divider passes one source period out of div plus one.
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					s_q_r <= 1'b0;
					cnt_r <= 8'h00;
					hit_r <= 1'b0;
				end else begin
					s_q_r <= s_lvl;
					if (s_lvl && !s_q_r) begin
						hit_r <= (cnt_r == 8'h00);
						cnt_r <= (cnt_r == 8'h00) ? div_r : cnt_r - 8'h01;
					end
				end
			end

			// Gated output; the pass test is made at the source's rising
			// edge itself, so a passed period is never cut or split.
			always_ff @(posedge clk_in) begin
				if (srst_in) begin
					out_r   <= 1'b0;
					out_q_r <= 1'b0;
					rc_r    <= 2'h0;
					half_r  <= 1'b0;
					qtr_r   <= 1'b0;
				end else begin
					out_r   <= s_lvl & gate_r &
						(s_q_r ? hit_r : (cnt_r == 8'h00));
					out_q_r <= out_r;
					half_r  <= out_r & !out_q_r & !rc_r[0];
					qtr_r   <= out_r & !out_q_r & (rc_r == 2'h0);
					if (out_r && !out_q_r) begin
						rc_r <= rc_r + 2'h1;
					end
				end
			end
			assign byp_vec[b] = byp_r;
		end
	endgenerate

	assign proc_clk_out         = g_blk[0].out_r;
	assign noc_clk_out          = g_blk[1].out_r;
	assign peripheral_bus_clock = g_blk[2].out_r;
	assign proc_half_en_out     = g_blk[0].half_r;
	assign proc_qtr_en_out      = g_blk[0].qtr_r;
	assign noc_half_en_out      = g_blk[1].half_r;
	assign noc_qtr_en_out       = g_blk[1].qtr_r;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);

	sequence s_warm;
		!pin_r[bcs_pkg::PIN_WARM] ##1 pin_r[bcs_pkg::PIN_WARM];
	endsequence

	a_boot_src_hold: assert property (
		$changed(boot_sel_r) |-> $past(cap_boot))
		else $error("boot source changed outside a boot exit");
	a_warm_boot_mode: assert property (
		s_warm |=> boot_mode_r)
		else $error("warm request did not enter boot mode");
	a_pbus_div_min: assert property (
		g_blk[2].div_r >= bcs_pkg::PB_MIN_DIV)
		else $error("peripheral bus divider below minimum");
	a_periph_en_boot: assert property (
		boot_mode_r |=> periph_en_out == 4'hF)
		else $error("peripheral enables not forced in boot mode");
	a_switch_low: assert property (
		$changed(g_blk[0].byp_r) || $changed(g_blk[0].gate_r)
		|-> !$past(g_blk[0].out_r) && !$past(g_blk[0].s_lvl))
		else $error("processor mux switched in high phase");
	a_proc_div_src: assert property (
		$changed(g_blk[0].div_r) |-> g_blk[0].div_r ==
		($past(safe_mode) ? bcs_pkg::SAFE_DIV : $past(pcnt_r)))
		else $error("processor divider from wrong source");
	a_ratio_pair: assert property (
		noc_qtr_en_out |-> noc_half_en_out)
		else $error("quarter enable without half enable");
	a_gate_closed: assert property (
		proc_clk_out |-> $past(g_blk[0].gate_r))
		else $error("processor clock ran through closed gate");
	a_stat_read: assert property (
		rd_in && addr_in == bcs_pkg::OFF_STAT
		|=> rdata_out[0] == $past(boot_mode_r))
		else $error("status read wrong boot mode");
endmodule : bcs_clk_ctrl

// File: verification/bcs_src_model.sv
// Source clock model standing on the far side of the clock block.
`timescale 1ns/1ps
module bcs_src_model (
	input  wire logic       clk_in,   // System clock.
	output logic            ext_out,  // External oscillator level.
	output logic            fab_out,  // Fabric reference level.
	output logic            int_out,  // Internal fast oscillator level.
	output logic [8:0]      main_out, // Main PLL counter levels.
	output logic [8:0]      per_out   // Peripheral PLL counter levels.
);
	int cnt = 0; // Free running cycle count.
	// Counts cycles; every source is a square wave derived from it.
	always @(posedge clk_in) begin
		cnt <= cnt + 1;
	end
	// Sources run free and stay slow enough to survive two-flop sampling.
	assign ext_out = 1'((cnt / 2) % 2);
	assign fab_out = 1'((cnt / 3) % 2);
	assign int_out = 1'((cnt / 4) % 2);
	// Main PLL counter k has half period 2+k cycles, peripheral PLL counter k has 3+k.
	for (genvar k = 0; k < 9; k++) begin : g_cnt
		assign main_out[k] = 1'((cnt / (2 + k)) % 2);
		assign per_out[k]  = 1'((cnt / (3 + k)) % 2);
	end
endmodule : bcs_src_model

// File: verification/tb_boot_clock_source_control.sv
// Self-checking testbench for the boot clock and source control block.
`timescale 1ns/1ps
module tb_boot_clock_source_control;
	// ****************************************
	// Signals
	// ****************************************
	logic        clk_in, srst_in;         // Clock and reset.
	logic [7:0]  addr_in;                 // Register address.
	logic [31:0] wdata_in, rdata_out;     // Register data.
	logic        wr_in, rd_in;            // Register strobes.
	logic        strap, warm;             // Boot pins.
	logic        ext_osc, fab_ref, int_osc; // Source levels.
	logic [8:0]  main_cnt, per_cnt;       // PLL counter levels.
	logic        boot_clk, proc_clk, noc_clk, pbus_clk; // Output clocks.
	logic        ph, pq, nh, nq;          // Ratio enables.
	logic [3:0]  pen;                     // Peripheral enables.
	logic [1:0]  prst;                    // PLL resets.
	logic        pbyp;                    // PLL bypass.
	int          mismatches, compares, cycles; // Bookkeeping.
	int          n [8];                   // Rising edges seen per output.
	// ****************************************
	// Design and source model
	// ****************************************
	bcs_clk_ctrl uut (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .boot_src_strap_in(strap),
		.warm_boot_req_in(warm), .external_oscillator_input(ext_osc),
		.fabric_free_reference(fab_ref), .int_fast_osc_in(int_osc),
		.main_pll_in(main_cnt), .peripheral_pll_in(per_cnt),
		.boot_clk_out(boot_clk), .proc_clk_out(proc_clk),
		.noc_clk_out(noc_clk), .peripheral_bus_clock(pbus_clk),
		.proc_half_en_out(ph), .proc_qtr_en_out(pq),
		.noc_half_en_out(nh), .noc_qtr_en_out(nq), .periph_en_out(pen),
		.pll_rst_out(prst), .pll_byp_out(pbyp));
	bcs_src_model src (.clk_in(clk_in), .ext_out(ext_osc), .fab_out(fab_ref),
		.int_out(int_osc), .main_out(main_cnt), .per_out(per_cnt));
	// Clock generator, 50 ns period.
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	// Compares one value and reports a difference at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	// Accepts an edge count within two of the expected one.
	task automatic near(input int got, input int exp, input string what);
		chk(32'(got >= exp - 2 && got <= exp + 2), 32'h1, what);
	endtask : near
	// One-cycle register write.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= d;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask : wr
	// One-cycle register read; data is taken in the following cycle.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input string what);
		@(posedge clk_in);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, exp, what);
	endtask : rdchk
	// Counts rising edges of the output clocks and enables over w cycles.
	task automatic measure(input int w);
		logic [7:0] prv;
		logic [7:0] cur;
		prv = '0;
		foreach (n[i]) n[i] = 0;
		repeat (w) begin
			@(posedge clk_in);
			#1;
			cur = {nq, nh, pq, ph, pbus_clk, noc_clk, proc_clk,
				boot_clk};
			for (int i = 0; i < 8; i++) begin
				if (cur[i] === 1'b1 && prv[i] !== 1'b1) n[i]++;
			end
			prv = cur;
		end
	endtask : measure
	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values and clocks running from the boot clock.
	task automatic t_reset();
		rdchk(bcs_pkg::OFF_CTRL, 32'h1, "ctrl reset");
		rdchk(bcs_pkg::OFF_EN, 32'h7F, "en reset");
		rdchk(bcs_pkg::OFF_PCNT, 32'h0, "pcnt reset");
		rdchk(bcs_pkg::OFF_PDIV, 32'h1, "pdiv reset");
		rdchk(bcs_pkg::OFF_STAT, 32'h1F, "status reset");
		rdchk(8'h40, 32'h0, "unmapped read");
		chk(32'(pen), 32'hF, "periph en reset");
		chk(32'(pbyp), 32'h1, "bypass reset");
		measure(240);
		near(n[0], 60, "boot clk ext");
		near(n[1], 60, "proc on boot");
		near(n[2], 60, "noc on boot");
		near(n[3], 30, "pbus safe div");
		$display("test reset done");
	endtask : t_reset
	// Boot mode holds peripheral enables on until it is left.
	task automatic t_boot_force();
		wr(bcs_pkg::OFF_EN, 32'h07);
		repeat (3) @(posedge clk_in);
		chk(32'(pen), 32'hF, "forced enables");
		wr(bcs_pkg::OFF_CTRL, 32'h0);
		repeat (8) @(posedge clk_in);
		chk(32'(pen), 32'h0, "enables off");
		chk(32'(pbyp), 32'h0, "bypass off");
		rdchk(bcs_pkg::OFF_STAT, 32'h2, "status run");
		wr(bcs_pkg::OFF_EN, 32'h7F);
		$display("test boot force done");
	endtask : t_boot_force
	// Every source code, with a middle and the top PLL counter.
	task automatic t_sources();
		logic [7:0] sel [6];
		int         ex  [6];
		sel = '{8'h00, 8'h01, 8'h02, 8'h13, 8'h14, 8'h43};
		ex  = '{60, 40, 15, 30, 24, 12};
		for (int c = 0; c < 6; c++) begin
			wr(bcs_pkg::OFF_CTRL, 32'h2);
			wr(bcs_pkg::OFF_SRCSEL, {16'h0, sel[c], sel[c]});
			wr(bcs_pkg::OFF_CTRL, 32'h0);
			repeat (10) @(posedge clk_in);
			measure(240);
			near(n[1], ex[c], "proc source rate");
			near(n[2], ex[c], "noc source rate");
			near(n[4], ex[c] / 2, "proc half enable");
			near(n[5], ex[c] / 4, "proc quarter enable");
			near(n[6], ex[c] / 2, "noc half enable");
			near(n[7], ex[c] / 4, "noc quarter enable");
		end
		wr(bcs_pkg::OFF_SRCSEL, 32'h0);
		$display("test sources done");
	endtask : t_sources
	// Processor scaling, divider floor and software gates.
	task automatic t_scale();
		wr(bcs_pkg::OFF_PCNT, 32'h3);
		wr(bcs_pkg::OFF_PDIV, 32'h0);
		rdchk(bcs_pkg::OFF_PDIV, 32'h0, "pdiv stored raw");
		repeat (10) @(posedge clk_in);
		measure(240);
		near(n[1], 15, "proc scaled");
		near(n[2], 60, "noc unscaled");
		near(n[3], 30, "pbus capped");
		chk(32'(prst), 32'h0, "plls untouched");
		wr(bcs_pkg::OFF_EN, 32'h7E);
		repeat (10) @(posedge clk_in);
		measure(240);
		near(n[1], 0, "proc gated");
		near(n[2], 60, "noc ungated");
		wr(bcs_pkg::OFF_EN, 32'h7F);
		$display("test scale done");
	endtask : t_scale
	// PLL reset forces safe dividers and bypass without a block reset.
	task automatic t_safe();
		wr(bcs_pkg::OFF_CTRL, 32'hC);
		repeat (8) @(posedge clk_in);
		chk(32'(prst), 32'h3, "pll resets");
		chk(32'(pbyp), 32'h1, "bypass forced");
		rdchk(bcs_pkg::OFF_STAT, 32'h1E, "status safe");
		measure(240);
		near(n[1], 60, "proc safe div");
		rdchk(bcs_pkg::OFF_PCNT, 32'h3, "pcnt kept");
		wr(bcs_pkg::OFF_CTRL, 32'h0);
		repeat (10) @(posedge clk_in);
		measure(240);
		near(n[1], 15, "proc restored");
		$display("test safe done");
	endtask : t_safe
	// Strap is ignored while running and taken again on a warm request.
	task automatic t_warm();
		@(posedge clk_in);
		strap <= 1'b0;
		repeat (6) @(posedge clk_in);
		rdchk(bcs_pkg::OFF_STAT, 32'h2, "strap ignored");
		@(posedge clk_in);
		warm <= 1'b1;
		repeat (10) @(posedge clk_in);
		rdchk(bcs_pkg::OFF_STAT, 32'h1D, "warm boot");
		chk(32'(pen), 32'hF, "warm enables");
		measure(240);
		near(n[0], 15, "boot clk internal");
		near(n[1], 15, "proc on boot");
		@(posedge clk_in);
		warm <= 1'b0;
		$display("test warm done");
	endtask : t_warm
	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{mismatches, compares, cycles} = '0;
		{srst_in, strap} = 2'b11;
		{wr_in, rd_in, warm} = '0;
		addr_in  = 8'h00;
		wdata_in = 32'h0;
		repeat (4) @(posedge clk_in);
		srst_in <= 1'b0;
		t_reset();
		t_boot_force();
		t_sources();
		t_scale();
		t_safe();
		t_warm();
		give_verdict();
	end
endmodule : tb_boot_clock_source_control
